//--- logic/bpl_config_load.sv
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "bpl_defines.svh"
module bpl_config_load
	import bpl_pkg::*;
#(
	parameter int unsigned POR_FAST_CYC = `BPL_POR_FAST_CYC,
	parameter int unsigned POR_STD_CYC  = `BPL_POR_STD_CYC,
	parameter int unsigned RESTART_CYC  = `BPL_RESTART_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        restart_request_low,
	input  wire logic        load_health_low_i,
	output logic             load_health_low_o,
	output logic             load_health_low_oe,
	input  wire logic        load_complete_i,
	output logic             load_complete_o,
	output logic             load_complete_oe,
	input  wire logic        load_strobe,
	input  wire logic [7:0]  load_data,
	input  wire logic [3:0]  scheme_select,
	input  wire logic        user_startup_clock,
	output logic             init_done_o,
	output logic             init_done_oe,
	output logic             user_io_hiz,
	output logic             user_io_pullup,
	output logic             user_clock_pin_free,
	output logic             user_mode
);
	bpl_sync_if sif ();

	bpl_state_e  state_q;
	bpl_state_e  state_d;
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic [23:0] byte_cnt_q;
	logic [23:0] len_q;
	logic [7:0]  last_byte_q;
	logic [3:0]  ctrl_q;
	logic        rel_q;
	logic        fast_q;
	logic        sel_ok_q;
	logic        err_flag_q;
	logic        zero_q;
	logic [1:0]  div_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;

	// Pins cross into the aclk domain before anything reads them
	assign sif.raw = {scheme_select, load_data, user_startup_clock,
		load_strobe, load_complete_i, load_health_low_i,
		restart_request_low};

	bpl_pin_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    (sif)
	);

	// Named views of the synchronised pins
	wire       restart_lvl   = sif.lvl[`BPL_SI_RESTART];
	wire       health_lvl    = sif.lvl[`BPL_SI_HEALTH];
	wire       complete_rise = sif.rise[`BPL_SI_COMPLETE];
	wire       strobe_rise   = sif.rise[`BPL_SI_STROBE];
	wire       uclk_rise     = sif.rise[`BPL_SI_UCLK];
	wire [7:0] data_lvl      = sif.lvl[`BPL_SI_DATA +: 8];
	wire [3:0] sel_lvl       = sif.lvl[`BPL_SI_SEL +: 4];

	// Control bits and the init clock choice
	wire uclk_en   = ctrl_q[`BPL_C_UCLK];
	wire auto_rst  = ctrl_q[`BPL_C_AUTORST];
	wire idone_en  = ctrl_q[`BPL_C_INITDONE];
	wire osc_tick  = (div_q == 2'(`BPL_OSC_DIV - 1));
	wire init_tick = uclk_en ? uclk_rise : osc_tick;
	wire sel_fast  = (sel_lvl == `BPL_SEL_FAST_33) ||
		(sel_lvl == `BPL_SEL_FAST_18);

	// Counter end points, all one below the wanted count
	wire [23:0] por_last  = fast_q ? 24'(POR_FAST_CYC - 1)
		: 24'(POR_STD_CYC - 1);
	wire [23:0] rst_last  = 24'(RESTART_CYC - 1);
	wire [23:0] cd_last   = 24'(`BPL_CD2CU_CYC - 1);
	wire [23:0] init_last = 24'(`BPL_INIT_CYC - 1);

	// Strobe edges count only while loading and before release
	wire        take_byte = (state_q == ST_LOAD) && strobe_rise &&
		!rel_q && sel_ok_q;
	wire [23:0] byte_next = byte_cnt_q + 24'h1;
	wire        err_req;

	// Sequencer: power-on, reset, load, delay, init, user
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + 24'h1;
		case (state_q)
			ST_POR: begin
				if (cnt_q == por_last) begin
					state_d = ST_RESET;
					cnt_d   = 24'h0;
				end
			end
			ST_RESET: begin
				cnt_d = 24'h0;
				if (restart_lvl && health_lvl && sel_ok_q)
					state_d = ST_LOAD;
			end
			ST_LOAD: begin
				cnt_d = 24'h0;
				if (err_req)
					state_d = ST_ERROR;
				else if (!health_lvl)
					state_d = ST_RESET;
				else if (complete_rise)
					state_d = ST_CD2CU;
			end
			ST_CD2CU: begin
				if (cnt_q == cd_last) begin
					state_d = ST_INIT;
					cnt_d   = 24'h0;
				end
			end
			ST_INIT: begin
				cnt_d = cnt_q + 24'(init_tick);
				if (init_tick && cnt_q == init_last)
					state_d = ST_USER;
			end
			ST_USER: begin
				cnt_d = 24'h0;
			end
			ST_ERROR: begin
				if (!auto_rst)
					cnt_d = 24'h0;
				else if (cnt_q == rst_last) begin
					state_d = ST_RESET;
					cnt_d   = 24'h0;
				end
			end
			default: begin
				state_d = ST_POR;
				cnt_d   = 24'h0;
			end
		endcase
		// A low restart line overrides everything after power-on
		if (state_q != ST_POR && !restart_lvl) begin
			state_d = ST_RESET;
			cnt_d   = 24'h0;
		end
	end

	// State, counter and the 10 MHz enable divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_POR;
			cnt_q   <= 24'h0;
			div_q   <= 2'h0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			div_q   <= osc_tick ? 2'h0 : div_q + 2'h1;
		end
	end

	// Straps are re-read during power-on so they are settled at exit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_q   <= 1'b0;
			sel_ok_q <= 1'b0;
		end else if (state_q == ST_POR) begin
			fast_q   <= sel_fast;
			sel_ok_q <= sel_fast;
		end
	end

	// Byte capture and completion release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			byte_cnt_q  <= 24'h0;
			last_byte_q <= 8'h00;
			rel_q       <= 1'b0;
		end else if (state_q == ST_RESET || state_q == ST_POR) begin
			byte_cnt_q <= 24'h0;
			rel_q      <= 1'b0;
		end else if (take_byte) begin
			last_byte_q <= data_lvl;
			byte_cnt_q  <= byte_next;
			rel_q <= (byte_next >= len_q - 24'h1);
		end
	end

	// Pin drivers; open-drain lines only ever pull low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zero_q              <= 1'b0;
			load_health_low_oe  <= 1'b1;
			load_complete_oe    <= 1'b1;
			init_done_oe        <= 1'b0;
			user_io_hiz         <= 1'b1;
			user_io_pullup      <= 1'b0;
			user_mode           <= 1'b0;
			user_clock_pin_free <= 1'b0;
		end else begin
			load_health_low_oe <= (state_q == ST_POR) ||
				(state_q == ST_ERROR) || !restart_lvl;
			load_complete_oe <= !((state_q == ST_LOAD && rel_q) ||
				state_q == ST_CD2CU || state_q == ST_INIT ||
				state_q == ST_USER);
			init_done_oe <= idone_en && ((state_q == ST_LOAD &&
				byte_cnt_q != 24'h0) || state_q == ST_CD2CU ||
				state_q == ST_INIT);
			user_io_hiz    <= (state_q != ST_USER);
			user_io_pullup <= (state_q != ST_POR) &&
				(state_q != ST_USER);
			user_mode           <= (state_q == ST_USER);
			user_clock_pin_free <= !uclk_en;
		end
	end
	assign load_health_low_o = zero_q;
	assign load_complete_o   = zero_q;
	assign init_done_o       = zero_q;

	// Write path: address and data may arrive in either order
	wire wr_go  = aw_got_q && w_got_q && !s_axi_bvalid;
	wire wa_ctl = (aw_addr_q == `BPL_A_CTRL);
	wire wa_len = (aw_addr_q == `BPL_A_LEN);
	wire wa_st  = (aw_addr_q == `BPL_A_STAT);
	wire wa_ok  = wa_ctl || wa_len || wa_st;
	wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire [31:0] len_new  = ({8'h00, len_q} & ~wmask) | (w_data_q & wmask);
	wire [31:0] ctrl_new = ({28'h0, ctrl_q} & ~wmask) |
		(w_data_q & wmask);
	assign err_req = ctrl_q[`BPL_C_ERR];
	wire err_set  = (state_d == ST_ERROR) && (state_q != ST_ERROR);
	wire err_clr  = wr_go && wa_st && w_strb_q[0] &&
		w_data_q[`BPL_S_ERR];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BPL_RESP_OKAY;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q      <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q      <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wa_ok ? `BPL_RESP_OKAY
					: `BPL_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Software registers; error request clears itself once seen in load, and at once in any other state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q     <= `BPL_CTRL_RST;
			len_q      <= `BPL_LEN_RST;
			err_flag_q <= 1'b0;
		end else begin
			if (wr_go && wa_ctl)
				ctrl_q <= ctrl_new[3:0];
			else if (state_q != ST_LOAD)
				ctrl_q[`BPL_C_ERR] <= 1'b0;
			else if (err_req)
				ctrl_q[`BPL_C_ERR] <= 1'b0;
			if (wr_go && wa_len)
				len_q <= len_new[23:0];
			// A new error beats a clear in the same cycle
			if (err_set)
				err_flag_q <= 1'b1;
			else if (err_clr)
				err_flag_q <= 1'b0;
		end
	end

	// Read path; unmapped reads return zero with SLVERR
	wire ra_ctl = (s_axi_araddr == `BPL_A_CTRL);
	wire ra_len = (s_axi_araddr == `BPL_A_LEN);
	wire ra_st  = (s_axi_araddr == `BPL_A_STAT);
	wire ra_cnt = (s_axi_araddr == `BPL_A_COUNT);
	wire ra_byt = (s_axi_araddr == `BPL_A_BYTE);
	wire ra_ok  = ra_ctl || ra_len || ra_st || ra_cnt || ra_byt;
	wire [31:0] rd_mux = ra_ctl ? {28'h0, ctrl_q}
		: ra_len ? {8'h00, len_q}
		: ra_st  ? {26'h0, err_flag_q, sel_ok_q, fast_q, state_q}
		: ra_cnt ? {8'h00, byte_cnt_q}
		: ra_byt ? {24'h0, last_byte_q} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `BPL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= ra_ok ? `BPL_RESP_OKAY : `BPL_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks on the sequencer and the pins
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_POR_HOLDS_LOW: assert property (
		state_q == ST_POR |=> load_health_low_oe && user_io_hiz)
		else $error("status not held low during power-on");
	AST_FLOAT_TO_USER: assert property (
		state_q == ST_LOAD ##1 state_q == ST_LOAD
		|-> user_io_hiz && user_io_pullup)
		else $error("pins not floating with pull-ups");
	AST_RESET_STAYS: assert property (
		state_q == ST_RESET && (!restart_lvl || !health_lvl)
		|=> state_q == ST_RESET)
		else $error("left reset with a line low");
	AST_STATUS_FREED: assert property (
		state_q == ST_RESET && restart_lvl |=> !load_health_low_oe)
		else $error("status not released on restart high");
	AST_BYTE_TAKEN: assert property (
		take_byte |=> byte_cnt_q == $past(byte_cnt_q) + 24'h1)
		else $error("byte not counted");
	AST_BYTE_LATCHED: assert property (
		take_byte |=> last_byte_q == $past(data_lvl))
		else $error("wrong byte captured");
	AST_COMPLETE_FREED: assert property (
		take_byte && byte_next == len_q - 24'h1 && restart_lvl
		##1 state_q == ST_LOAD |=> !load_complete_oe)
		else $error("completion not released after next-to-last");
	AST_STROBE_IGNORED: assert property (
		rel_q && strobe_rise && state_q != ST_RESET
		|=> $stable(byte_cnt_q) && $stable(last_byte_q))
		else $error("strobe changed state after completion");
	AST_INIT_TO_USER: assert property (
		state_q == ST_INIT && init_tick && cnt_q == init_last &&
		restart_lvl |=> state_q == ST_USER ##1 user_mode)
		else $error("user mode not entered after last init cycle");
	AST_INIT_NOT_EARLY: assert property (
		state_q == ST_INIT && cnt_q < init_last |=> state_q != ST_USER)
		else $error("user mode entered early");
	AST_ERROR_LOW: assert property (
		err_req && state_q == ST_LOAD && restart_lvl
		|=> state_q == ST_ERROR ##1 load_health_low_oe)
		else $error("error did not pull status low");
	AST_INITDONE_FREE: assert property (
		state_q == ST_USER |=> !init_done_oe)
		else $error("init-done still low in user mode");

	COV_USER_MODE: cover property ($rose(user_mode));
	COV_RELEASE: cover property ($rose(rel_q));
	COV_AUTO_RESTART: cover property (
		state_q == ST_ERROR ##1 state_q == ST_RESET);
endmodule // bpl_config_load

//--- common/bpl_defines.svh
`ifndef BPL_DEFINES_SVH
`define BPL_DEFINES_SVH

// Clock and derived rates
`define BPL_CLK_HZ         40000000
`define BPL_CLK_MHZ        (`BPL_CLK_HZ / 1000000)
`define BPL_OSC_HZ         10000000
`define BPL_OSC_DIV        (`BPL_CLK_HZ / `BPL_OSC_HZ)
// Power-on delays in microseconds; strictly longer than the minimum
`define BPL_POR_FAST_MIN_US 3000
`define BPL_POR_FAST_MAX_US 9000
`define BPL_POR_STD_MIN_US  50000
`define BPL_POR_STD_MAX_US  200000
`define BPL_POR_FAST_CYC   (`BPL_POR_FAST_MIN_US * `BPL_CLK_MHZ + 1)
`define BPL_POR_STD_CYC    (`BPL_POR_STD_MIN_US * `BPL_CLK_MHZ + 1)
// Error time-out, a longest time, rounds down
`define BPL_RESTART_US     230
`define BPL_RESTART_CYC    (`BPL_RESTART_US * `BPL_CLK_MHZ)
// Completion-to-user-clock delay, a least time, rounds up
`define BPL_CD2CU_NS       1000
`define BPL_CD2CU_CYC      ((`BPL_CD2CU_NS * `BPL_CLK_MHZ + 999) / 1000)
`define BPL_INIT_CYC       3187
// Select pin encodings
`define BPL_SEL_FAST_33    4'he
`define BPL_SEL_FAST_18    4'hf
// Synchroniser bit positions
`define BPL_SYNC_W         17
`define BPL_SI_RESTART     0
`define BPL_SI_HEALTH      1
`define BPL_SI_COMPLETE    2
`define BPL_SI_STROBE      3
`define BPL_SI_UCLK        4
`define BPL_SI_DATA        5
`define BPL_SI_SEL         13
// Register byte addresses
`define BPL_A_CTRL         8'h00
`define BPL_A_LEN          8'h04
`define BPL_A_STAT         8'h08
`define BPL_A_COUNT        8'h0c
`define BPL_A_BYTE         8'h10
// Control fields and reset values
`define BPL_C_INITDONE     0
`define BPL_C_UCLK         1
`define BPL_C_AUTORST      2
`define BPL_C_ERR          3
`define BPL_S_ERR          5
`define BPL_CTRL_RST       4'h0
`define BPL_LEN_RST        24'h000100
`define BPL_RESP_OKAY      2'h0
`define BPL_RESP_SLVERR    2'h2
`endif

//--- common/bpl_pkg.sv
package bpl_pkg;
	// Gray along power-on, reset, load, delay, init, user
	typedef enum logic [2:0] {
		ST_POR   = 3'h0,
		ST_RESET = 3'h1,
		ST_LOAD  = 3'h3,
		ST_CD2CU = 3'h2,
		ST_INIT  = 3'h6,
		ST_USER  = 3'h7,
		ST_ERROR = 3'h5
	} bpl_state_e;
endpackage

//--- common/bpl_sync_if.sv
`timescale 1ns/1ps
`include "bpl_defines.svh"
interface bpl_sync_if;
	logic [`BPL_SYNC_W-1:0] raw;
	logic [`BPL_SYNC_W-1:0] lvl;
	logic [`BPL_SYNC_W-1:0] rise;
	modport sync (input raw, output lvl, output rise);
	modport user (output raw, input lvl, input rise);
endinterface

//--- logic/bpl_pin_sync.sv
`timescale 1ns/1ps
`include "bpl_defines.svh"
module bpl_pin_sync
	import bpl_pkg::*;
(
	input wire logic  aclk,
	input wire logic  aresetn,
	bpl_sync_if.sync  pins
);
	// Two stages per pin, a third only for edge finding
	for (genvar i = 0; i < `BPL_SYNC_W; i++) begin : g_bit
		logic meta_q;
		logic lvl_q;
		logic prev_q;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				meta_q <= 1'b0;
				lvl_q  <= 1'b0;
				prev_q <= 1'b0;
			end else begin
				meta_q <= pins.raw[i];
				lvl_q  <= meta_q;
				prev_q <= lvl_q;
			end
		end
		assign pins.lvl[i]  = lvl_q;
		assign pins.rise[i] = lvl_q & ~prev_q;
	end
endmodule // bpl_pin_sync

//--- verification/bpl_host_model.sv
`timescale 1ns/1ps
module bpl_host_model
	import bpl_pkg::*;
(
	input  wire logic  aclk,
	input  wire logic  status_line,
	input  wire logic  complete_line,
	output logic       restart_request_low,
	output logic       load_strobe,
	output logic [7:0] load_data
);
	int unsigned sent;
	logic        failed;

	// Restart held low, strobe still and bus idle at power-up
	initial begin
		restart_request_low = 1'b0;
		load_strobe = 1'b0;
		load_data = 8'h00;
		sent = 0;
		failed = 1'b0;
	end

	// Low for low_cyc cycles (20 is 500 ns); rise=0 leaves it low
	task automatic restart(input int low_cyc, input bit rise);
		@(posedge aclk);
		restart_request_low <= 1'b0;
		repeat (low_cyc) @(posedge aclk);
		if (rise) restart_request_low <= 1'b1;
	endtask

	// Data stands four cycles before the rise and five after it, so that a
	// completion release caused by this byte is seen before the next one
	task automatic strobe_byte(input logic [7:0] b);
		@(posedge aclk);
		load_strobe <= 1'b0;
		load_data <= b;
		repeat (4) @(posedge aclk);
		load_strobe <= 1'b1;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
	endtask

	// Whole image until completion is seen; stray strobes afterwards
	task automatic send_image(input logic [7:0] img[$], input int pause,
			input int extra);
		int w;
		sent = 0;
		w = 0;
		do begin
			@(negedge aclk);
			w++;
		end while (status_line !== 1'b1 && w < 400);
		foreach (img[i]) begin
			if (complete_line === 1'b1) break;
			strobe_byte(img[i]);
			sent++;
			if (i == 1) repeat (pause) @(negedge aclk);
		end
		repeat (extra) strobe_byte(8'h00);
		@(posedge aclk);
		load_strobe <= 1'b0;
		load_data <= ~load_data; // Released bus does not keep the last byte
		failed = (complete_line !== 1'b1);
	endtask
endmodule // bpl_host_model

//--- verification/byte_parallel_config_load_tb.sv
`timescale 1ns/1ps
`include "bpl_defines.svh"
module byte_parallel_config_load_tb
	import bpl_pkg::*;
;
	localparam int         POR_F = 20;
	localparam int         POR_S = 30;
	localparam int         RST_C = 16;
	localparam logic [1:0] OK    = `BPL_RESP_OKAY;
	localparam logic [1:0] ERR   = `BPL_RESP_SLVERR;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [3:0]  scheme_select = 4'h3;
	logic        user_startup_clock = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire         s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         restart_request_low, load_strobe;
	wire  [7:0]  load_data;
	wire         load_health_low_o, load_health_low_oe;
	wire         load_complete_o, load_complete_oe;
	wire         init_done_o, init_done_oe, user_io_hiz, user_io_pullup;
	wire         user_clock_pin_free, user_mode;
	int          num_errors = 0;
	int          n_tests = 0;

	// Open-drain lines with board pull-ups; host and device read the same
	wire load_health_low_i = !(load_health_low_oe && !load_health_low_o);
	wire load_complete_i = !(load_complete_oe && !load_complete_o);
	wire status_line = load_health_low_i;
	wire complete_line = load_complete_i;

	// 40 MHz clock
	always #12.5 aclk = ~aclk;

	bpl_config_load #(
		.POR_FAST_CYC(POR_F),
		.POR_STD_CYC(POR_S),
		.RESTART_CYC(RST_C)
	) bpl_config_load_inst (.*);

	bpl_host_model bpl_host_model_inst (.*);

	// Fast straps; anything else gets the standard delay
	function automatic logic fast_sel(input logic [3:0] s);
		return s == `BPL_SEL_FAST_33 || s == `BPL_SEL_FAST_18;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("wrong value at %0t: %h outside %h..%h", $time, got, lo, hi);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && t < 200);
		s_axi_bready <= 1'b0;
		chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
	endtask

	// Read one word and compare the masked value and the response
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && t < 200);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
	endtask

	// Counts falling edges until the status line shows v
	task automatic wait_line(input logic v, output int n);
		n = 0;
		while (status_line !== v && n < 200) begin
			@(negedge aclk);
			n++;
		end
	endtask

	// One full load; uc moves initialization onto the start-up clock
	task automatic load_run(input int n, input logic uc, input int pause);
		logic [7:0] img[$];
		int c, k, e;
		k = 0;
		e = 0;
		repeat (n) img.push_back(8'($urandom));
		wr(`BPL_A_LEN, n, OK);
		wr(`BPL_A_CTRL, {30'h0, uc, 1'b1}, OK);
		bpl_host_model_inst.restart(20, 1'b1);
		fork
			bpl_host_model_inst.send_image(img, pause, 3);
			for (c = 0; user_mode !== 1'b1 && c < 40000; c++) begin
				@(posedge aclk);
				k += int'(complete_line);
				if (k == 200) chk({31'h0, init_done_oe}, 32'h1);
				if (uc && c % 3 == 0) begin
					user_startup_clock <= !user_startup_clock;
					e += int'(complete_line && !user_startup_clock);
				end
			end
		join
		chk(32'(bpl_host_model_inst.sent), n - 1);
		chk({31'h0, bpl_host_model_inst.failed}, 32'h0);
		rd_chk(`BPL_A_COUNT, 32'hffffffff, n - 1, OK);
		rd_chk(`BPL_A_BYTE, 32'hff, {24'h0, img[n - 2]}, OK);
		if (uc) chk_rng(e, 3190, 3200);
		else chk_rng(k, 12785, 12797);
		chk({28'h0, user_mode, user_io_hiz, user_io_pullup, init_done_oe},
			32'h8);
		chk({31'h0, user_clock_pin_free}, {31'h0, !uc});
		$display("load test done: %0d bytes, start-up clock %0d", n, uc);
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog sized well past both initialization runs
	initial begin
		repeat (80000) @(posedge aclk);
		num_errors++;
		final_report();
	end

	// Strap sweep, address map, two loads, then an injected error
	initial begin
		logic [3:0] straps[3];
		logic       s;
		int         n;
		straps = '{4'h3, `BPL_SEL_FAST_33, `BPL_SEL_FAST_18};
		void'($urandom(92));
		foreach (straps[i]) begin
			bpl_host_model_inst.restart(0, 1'b0);
			s = fast_sel(straps[i]);
			scheme_select <= straps[i];
			aresetn <= 1'b0;
			repeat (8) @(posedge aclk);
			aresetn <= 1'b1;
			@(negedge aclk);
			chk({29'h0, status_line, user_io_hiz, user_io_pullup}, 32'h2);
			n = 0;
			while (user_io_pullup !== 1'b1 && n < 100) begin
				@(negedge aclk);
				n++;
			end
			chk_rng(n - (s ? POR_F : POR_S), -2, 4);
			chk({30'h0, status_line, user_io_hiz}, 32'h1);
			rd_chk(`BPL_A_STAT, 32'h18, {27'h0, s, s, 3'h0}, OK);
			if (i == 0) begin
				rd_chk(`BPL_A_LEN, 32'hffffffff, 32'h100, OK);
				rd_chk(`BPL_A_CTRL, 32'hf, 32'h0, OK);
			end
			bpl_host_model_inst.restart(20, 1'b1);
			repeat (20) @(negedge aclk);
			chk({31'h0, status_line}, 32'h1);
			rd_chk(`BPL_A_STAT, 32'h7, s ? 32'h3 : 32'h1, OK);
			$display("strap test done: select %h", straps[i]);
		end
		wr(8'h40, 32'h1, ERR);
		rd_chk(8'h40, 32'hffffffff, 32'h0, ERR);
		wr(`BPL_A_COUNT, 32'h0, ERR);
		$display("address map test done");
		load_run($urandom_range(3, 10), 1'b0, 0);
		load_run($urandom_range(4, 12), 1'b1, 300);
		bpl_host_model_inst.restart(20, 1'b1);
		wait_line(1'b1, n);
		wr(`BPL_A_CTRL, 32'hc, OK);
		wait_line(1'b0, n);
		chk_rng(n, 0, 4);
		wait_line(1'b1, n);
		chk_rng(n, RST_C - 4, RST_C + 4);
		rd_chk(`BPL_A_STAT, 32'h20, 32'h20, OK);
		wr(`BPL_A_STAT, 32'h20, OK);
		rd_chk(`BPL_A_STAT, 32'h20, 32'h0, OK);
		$display("error test done");
		final_report();
	end
endmodule // byte_parallel_config_load_tb
